// ===== hw/ebrw_map.vh
`ifndef EBRW_MAP_VH
`define EBRW_MAP_VH

// Phase state codes, one-hot
`define EBRW_ST_IDLE 7'h01
`define EBRW_ST_AB 7'h02
`define EBRW_ST_C 7'h04
`define EBRW_ST_D 7'h08
`define EBRW_ST_E 7'h10
`define EBRW_ST_RDY 7'h20
`define EBRW_ST_F 7'h40

// Timing configuration word layout (per chip-select window)
`define EBRW_CFG_W 16
`define EBRW_CFG_AB_LSB 0
`define EBRW_CFG_C_LSB 1
`define EBRW_CFG_D_LSB 3
`define EBRW_CFG_E_LSB 4
`define EBRW_CFG_F_LSB 9
`define EBRW_CFG_RDYEN_BIT 11
`define EBRW_CFG_RDYASYNC_BIT 12
`define EBRW_CFG_RDYPOL_BIT 13

// Reset value of every window's configuration: ready control off
`define EBRW_CFG_RESET 16'h0000

// Phase length limits in chip-select clock units
`define EBRW_AB_MIN 1
`define EBRW_E_MIN 1
`define EBRW_E_MAX 32

`endif

// ===== hw/ebrw_ctrl.v
`include "ebrw_map.vh"
`timescale 1ns/1ps
`default_nettype none

module ebrw_ctrl #(
    parameter WINDOWS = 4,
    parameter WIN_W = 2,
    parameter ADDR_W = 24,
    parameter DATA_W = 16
) (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_clk_en,
    input wire i_cfg_we,
    input wire [WIN_W-1:0] i_cfg_win,
    input wire [`EBRW_CFG_W-1:0] i_cfg_data,
    input wire i_req,
    input wire i_req_write,
    input wire [WIN_W-1:0] i_req_win,
    input wire [ADDR_W-1:0] i_req_addr,
    input wire [DATA_W-1:0] i_req_wdata,
    input wire i_req_upper,
    input wire i_ready,
    input wire [DATA_W-1:0] i_rdata,
    output reg o_busy,
    output reg o_done,
    output reg [DATA_W-1:0] o_rdata,
    output reg o_bus_ref_clock_out,
    output reg [ADDR_W-1:0] o_addr,
    output reg o_read_strobe_n,
    output reg o_write_strobe_n,
    output reg [WINDOWS-1:0] o_chip_sel_n,
    output reg o_upper_byte_enable_n,
    output reg [DATA_W-1:0] o_wdata,
    output reg o_wdata_oe,
    output reg o_wait_state
);

////////////////////////////////////////////////////////////////////////////////
// Reset release and clock-domain inputs

reg [1:0] rst_sync_r;
wire rst_n = rst_sync_r[1];

always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
        rst_sync_r <= 2'h0;
    end else begin
        rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
end

// Three-stage chain for asynchronous ready; change taken once stages 2 and 3 agree
reg [2:0] rdy_sync_r;
reg rdy_async_r;
always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
        rdy_sync_r <= 3'h0;
        rdy_async_r <= 1'b0;
    end else if (i_clk_en) begin
        rdy_sync_r <= {rdy_sync_r[1:0], i_ready};
        if (rdy_sync_r[1] == rdy_sync_r[2]) begin
            rdy_async_r <= rdy_sync_r[2];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Per-window timing configuration

reg [`EBRW_CFG_W-1:0] cfg_r [0:WINDOWS-1];
genvar gi;
generate
    for (gi = 0; gi < WINDOWS; gi = gi + 1) begin : g_cfg
        always @(posedge i_clock or negedge rst_n) begin
            if (!rst_n) begin
                cfg_r[gi] <= `EBRW_CFG_RESET;
            end else if (i_clk_en && i_cfg_we && i_cfg_win == gi) begin
                cfg_r[gi] <= i_cfg_data;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Bus cycle sequencer

reg [6:0] state_r;
reg [6:0] state_nxt;
reg [5:0] cnt_r;
reg [5:0] cnt_nxt;
reg [`EBRW_CFG_W-1:0] cur_r;
reg write_r;

// Address setup extension is read from the window being requested, before cur_r loads
wire ab_ext = cfg_r[i_req_win][`EBRW_CFG_AB_LSB];
wire [1:0] len_c = cur_r[`EBRW_CFG_C_LSB +: 2];
wire [0:0] len_d = cur_r[`EBRW_CFG_D_LSB];
wire [4:0] len_e = cur_r[`EBRW_CFG_E_LSB +: 5];
wire [1:0] len_f = cur_r[`EBRW_CFG_F_LSB +: 2];
wire rdy_en = cur_r[`EBRW_CFG_RDYEN_BIT];
wire rdy_async = cur_r[`EBRW_CFG_RDYASYNC_BIT];
wire rdy_pol = cur_r[`EBRW_CFG_RDYPOL_BIT];

// Sync mode takes the pin as is; async uses the filtered copy, so sampling lags
wire rdy_raw = rdy_async ? rdy_async_r : i_ready;
wire rdy_active = (rdy_raw == rdy_pol);

// Phase entry with the zero-length phases skipped, counter loaded with length-1
always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r - 6'h01;
    case (state_r)
        `EBRW_ST_IDLE: begin
            cnt_nxt = 6'h00;
            if (i_req) begin
                state_nxt = `EBRW_ST_AB;
                cnt_nxt = {5'h00, ab_ext};
            end
        end
        `EBRW_ST_AB: begin
            if (cnt_r == 6'h00) begin
                if (len_c != 2'h0) begin
                    state_nxt = `EBRW_ST_C;
                    cnt_nxt = {4'h0, len_c} - 6'h01;
                end else if (len_d != 1'b0) begin
                    state_nxt = `EBRW_ST_D;
                    cnt_nxt = 6'h00;
                end else begin
                    state_nxt = `EBRW_ST_E;
                    cnt_nxt = {1'b0, len_e};
                end
            end
        end
        `EBRW_ST_C: begin
            if (cnt_r == 6'h00) begin
                if (len_d != 1'b0) begin
                    state_nxt = `EBRW_ST_D;
                    cnt_nxt = 6'h00;
                end else begin
                    state_nxt = `EBRW_ST_E;
                    cnt_nxt = {1'b0, len_e};
                end
            end
        end
        `EBRW_ST_D: begin
            state_nxt = `EBRW_ST_E;
            cnt_nxt = {1'b0, len_e};
        end
        `EBRW_ST_E: begin
            // Mandatory wait states elapse before ready is looked at
            if (cnt_r == 6'h00) begin
                // Async mode always waits once: its sample point sits one cycle later
                if (rdy_en && (rdy_async || !rdy_active)) begin
                    state_nxt = `EBRW_ST_RDY;
                end else if (len_f != 2'h0) begin
                    state_nxt = `EBRW_ST_F;
                    cnt_nxt = {4'h0, len_f} - 6'h01;
                end else begin
                    state_nxt = `EBRW_ST_IDLE;
                end
            end
        end
        `EBRW_ST_RDY: begin
            // One wait state per inactive sample, then sample again
            cnt_nxt = 6'h00;
            if (rdy_active) begin
                if (len_f != 2'h0) begin
                    state_nxt = `EBRW_ST_F;
                    cnt_nxt = {4'h0, len_f} - 6'h01;
                end else begin
                    state_nxt = `EBRW_ST_IDLE;
                end
            end
        end
        `EBRW_ST_F: begin
            if (cnt_r == 6'h00) begin
                state_nxt = `EBRW_ST_IDLE;
            end
        end
        default: begin
            state_nxt = `EBRW_ST_IDLE;
            cnt_nxt = 6'h00;
        end
    endcase
end

// Access ends on this edge: strobe rises, read data captured; address holds until the next request
// Entering a wait state is not an end, so the strobe stays low through it
wire access_end = (state_r == `EBRW_ST_E || state_r == `EBRW_ST_RDY) &&
    (state_nxt != state_r) && (state_nxt != `EBRW_ST_RDY);

always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
        state_r <= `EBRW_ST_IDLE;
        cnt_r <= 6'h00;
        cur_r <= `EBRW_CFG_RESET;
        write_r <= 1'b0;
        o_busy <= 1'b0;
        o_done <= 1'b0;
        o_rdata <= {DATA_W{1'b0}};
        o_bus_ref_clock_out <= 1'b0;
        o_addr <= {ADDR_W{1'b0}};
        o_read_strobe_n <= 1'b1;
        o_write_strobe_n <= 1'b1;
        o_chip_sel_n <= {WINDOWS{1'b1}};
        o_upper_byte_enable_n <= 1'b1;
        o_wdata <= {DATA_W{1'b0}};
        o_wdata_oe <= 1'b0;
        o_wait_state <= 1'b0;
    end else if (i_clk_en) begin
        state_r <= state_nxt;
        cnt_r <= cnt_nxt;
        o_done <= 1'b0;
        // Reference clock toggles with system clock, rising at every second sampling edge
        o_bus_ref_clock_out <= ~o_bus_ref_clock_out;
        if (state_r == `EBRW_ST_IDLE && i_req) begin
            cur_r <= cfg_r[i_req_win];
            write_r <= i_req_write;
            o_busy <= 1'b1;
            o_addr <= i_req_addr;
            o_wdata <= i_req_wdata;
            o_upper_byte_enable_n <= ~i_req_upper;
            o_chip_sel_n <= ~({{(WINDOWS-1){1'b0}}, 1'b1} << i_req_win);
        end
        // Command asserted on entry to the access phase
        if (state_nxt == `EBRW_ST_E && state_r != `EBRW_ST_E) begin
            o_read_strobe_n <= write_r;
            o_write_strobe_n <= ~write_r;
        end
        if (state_r == `EBRW_ST_D || (state_nxt == `EBRW_ST_E && write_r)) begin
            o_wdata_oe <= write_r;
        end
        o_wait_state <= (state_nxt == `EBRW_ST_RDY);
        if (access_end) begin
            o_read_strobe_n <= 1'b1;
            o_write_strobe_n <= 1'b1;
            // Latched here, so later address or data changes cannot corrupt it
            if (!write_r) begin
                o_rdata <= i_rdata;
            end
        end
        if (state_r != `EBRW_ST_IDLE && state_nxt == `EBRW_ST_IDLE) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
            o_chip_sel_n <= {WINDOWS{1'b1}};
            o_wdata_oe <= 1'b0;
            o_upper_byte_enable_n <= 1'b1;
        end
    end
end

endmodule
`default_nettype wire

// ===== verification/ebrw_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ebrw_ctrl_properties #(parameter WINDOWS = 4, parameter DATA_W = 16) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_req,
    input wire logic [DATA_W-1:0] i_rdata,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic o_bus_ref_clock_out,
    input wire logic o_read_strobe_n,
    input wire logic o_write_strobe_n,
    input wire logic [WINDOWS-1:0] o_chip_sel_n,
    input wire logic o_wait_state
);
// Single domain, reset silences every check
default clocking cb @(posedge i_clock); endclocking
default disable iff (!i_reset_n);
property p_done_idle; o_done |-> !o_busy; endproperty
a_done_idle: assert property (p_done_idle) else $error("done while busy");
property p_end_busy; $fell(o_busy) |-> o_done; endproperty
a_end_busy: assert property (p_end_busy) else $error("busy fell without done");
property p_req_start; i_req && i_clk_en && !o_busy |=> o_busy; endproperty
a_req_start: assert property (p_req_start) else $error("request not taken");
property p_rd_cs; !o_read_strobe_n |-> $onehot(~o_chip_sel_n); endproperty
a_rd_cs: assert property (p_rd_cs) else $error("read strobe without one select");
property p_one_strobe; o_read_strobe_n || o_write_strobe_n; endproperty
a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
property p_rdata_cap; $rose(o_read_strobe_n) |-> o_rdata == $past(i_rdata); endproperty
a_rdata_cap: assert property (p_rdata_cap) else $error("read data not taken at strobe end");
property p_wait_strobe; o_wait_state |-> o_busy && !(o_read_strobe_n && o_write_strobe_n); endproperty
a_wait_strobe: assert property (p_wait_strobe) else $error("wait state outside access");
property p_ref_clk; $changed(o_bus_ref_clock_out) ##1 i_clk_en |-> $changed(o_bus_ref_clock_out); endproperty
a_ref_clk: assert property (p_ref_clk) else $error("reference clock stalled");
endmodule
`default_nettype wire

// ===== verification/ebrw_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ebrw_mem_model (
    input wire logic i_clock,
    input wire logic i_strobe_n,
    input wire logic [15:0] i_pat,
    input wire logic [5:0] i_dly,
    input wire logic i_pol,
    output logic o_ready,
    output logic [15:0] o_rdata
);
logic [5:0] low_r = 6'h00;
initial o_ready = 1'b0;
initial o_rdata = 16'h0000;
// Strobe-low age sets how slow this memory answers
always @(posedge i_clock) begin
    low_r <= i_strobe_n ? 6'h00 : low_r + 6'h01;
end
// Ready moves half a cycle off the sampling edge; dropped half a cycle after strobe end
always @(negedge i_clock) begin
    o_ready <= ~((!i_strobe_n && low_r >= i_dly) ^ i_pol);
end
// Released bus flips each cycle, so stale data never looks valid
always @(negedge i_clock) begin
    o_rdata <= i_strobe_n ? ~o_rdata : i_pat;
end
endmodule
`default_nettype wire

// ===== verification/test_ext_bus_ready_wait_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_ext_bus_ready_wait_control;
logic i_clock = 1'b0;
logic i_reset_n = 1'b0;
logic cfg_we = 1'b0, req = 1'b0, req_wr = 1'b0, req_up = 1'b0, pol = 1'b1;
logic [1:0] cfg_win = 2'h0, req_win = 2'h0;
logic [15:0] cfg_data = 16'h0000, wdata = 16'h0000, pat = 16'h0000, d;
logic [23:0] addr = 24'h000000;
logic [5:0] dly = 6'h00;
logic [15:0] cfg_tab [0:3];
logic [15:0] q_dat[$];
logic q_rd[$];
logic [42:0] q_req[$];
int q_lo[$], q_hi[$];
int seed = 32'h15c2, err_total = 0, checks = 0, cyc = 0, m;
wire ready, busy, done, rs_n, ws_n;
wire [15:0] rdata, o_rdata, wd_o;
wire [23:0] addr_o;
wire [3:0] cs_n;
wire ube_n, wd_oe;
ebrw_ctrl dut_u (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_clk_en(1'b1), .i_cfg_we(cfg_we),
    .i_cfg_win(cfg_win), .i_cfg_data(cfg_data), .i_req(req), .i_req_write(req_wr), .i_req_win(req_win),
    .i_req_addr(addr), .i_req_wdata(wdata), .i_req_upper(req_up), .i_ready(ready), .i_rdata(rdata),
    .o_busy(busy), .o_done(done), .o_rdata(o_rdata), .o_bus_ref_clock_out(), .o_addr(addr_o),
    .o_read_strobe_n(rs_n), .o_write_strobe_n(ws_n), .o_chip_sel_n(cs_n), .o_upper_byte_enable_n(ube_n),
    .o_wdata(wd_o), .o_wdata_oe(wd_oe), .o_wait_state());
ebrw_mem_model mem_u (.i_clock(i_clock), .i_strobe_n(rs_n & ws_n), .i_pat(pat), .i_dly(dly), .i_pol(pol),
    .o_ready(ready), .o_rdata(rdata));
////////////////////////////////////////////////////////////////////////////////
// Clock and cycle count
always #5 i_clock = ~i_clock;
always @(posedge i_clock) cyc <= cyc + 1;
task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
        err_total++;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task automatic tally_and_finish;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
        $display("Testbench passed");
    end else begin
        $display("Testbench failed");
    end
    $finish;
endtask
task automatic set_cfg(input logic [1:0] w, input logic [15:0] v);
    cfg_we <= 1'b1;
    cfg_win <= w;
    cfg_data <= v;
    @(posedge i_clock);
    cfg_we <= 1'b0;
    @(posedge i_clock);
endtask
// One request; the expected end window goes to the queues
task automatic bus_cycle(input logic [1:0] w);
    logic [15:0] c, wd;
    logic [23:0] a;
    logic wr, hold, up;
    logic [5:0] nd;
    int b, n;
    c = cfg_tab[w];
    wr = 1'($random(seed));
    hold = 1'($random(seed));
    up = 1'($random(seed));
    a = 24'($random(seed));
    wd = 16'($random(seed));
    nd = 6'($random(seed)) & 6'h07;
    b = 3 + c[0] + c[2:1] + c[3] + c[8:4] + c[10:9];
    d = 16'($random(seed));
    pat <= d;
    dly <= nd;
    pol <= c[11] ? c[13] : 1'b1;
    // Partner settles its idle ready level under the new polarity before the request
    repeat (4) @(posedge i_clock);
    req <= 1'b1;
    req_win <= w;
    req_wr <= wr;
    req_up <= up;
    addr <= a;
    wdata <= wd;
    q_lo.push_back(cyc + 1 + b + (c[11] & c[12]));
    q_hi.push_back(cyc + 1 + b + (c[11] ? nd + 8 : 0));
    q_dat.push_back(d);
    q_rd.push_back(!wr);
    q_req.push_back({w, up, a, wd});
    @(posedge i_clock);
    if (!hold) req <= 1'b0;
    @(posedge i_clock);
    req <= 1'b0;
    for (n = 0; n < 300 && done !== 1'b1; n++) @(posedge i_clock);
    if (n == 300) begin
        err_total++;
        tally_and_finish;
    end
endtask
////////////////////////////////////////////////////////////////////////////////
// Completion monitor: oldest note against what appears
always @(posedge i_clock) begin
    // While a strobe is low: right strobe, one select, byte enable and data drive
    if ((rs_n & ws_n) === 1'b0 && q_req.size() != 0) begin
        check({14'h0000, rs_n, ws_n}, q_rd[0] ? 16'h0001 : 16'h0002);
        check({12'h000, cs_n}, {12'h000, ~(4'h1 << q_req[0][42:41])});
        check({14'h0000, ube_n, wd_oe}, {14'h0000, ~q_req[0][40], ~q_rd[0]});
    end
    if (done === 1'b1) begin
        if (q_lo.size() == 0) begin
            check(16'h0001, 16'h0000);
        end else begin
            check({15'h0000, cyc >= q_lo[0] && cyc <= q_hi[0]}, 16'h0001);
            if (q_rd[0]) check(o_rdata, q_dat[0]);
            check(addr_o[15:0], q_req[0][31:16]);
            check({8'h00, addr_o[23:16]}, {8'h00, q_req[0][39:32]});
            check(wd_o, q_req[0][15:0]);
            void'(q_lo.pop_front());
            void'(q_hi.pop_front());
            void'(q_dat.pop_front());
            void'(q_rd.pop_front());
            void'(q_req.pop_front());
        end
    end
end
// Every window gets every ready mode across the rounds
initial begin
    repeat (2) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    for (int r = 0; r < 5; r++) begin
        for (int w = 0; w < 4; w++) begin
            m = (r + w) % 5;
            d = 16'($random(seed));
            d[15:11] = {2'b00, m == 1 || m == 3, m > 2, m > 0};
            cfg_tab[w] = d;
            set_cfg(2'(w), d);
        end
        for (int i = 0; i < 8; i++) bus_cycle(2'($random(seed)));
    end
    tally_and_finish;
end
endmodule
bind ebrw_ctrl ebrw_ctrl_properties #(.WINDOWS(WINDOWS), .DATA_W(DATA_W)) props_u (.i_clock, .i_reset_n,
    .i_clk_en, .i_req, .i_rdata, .o_busy, .o_done, .o_rdata, .o_bus_ref_clock_out, .o_read_strobe_n,
    .o_write_strobe_n, .o_chip_sel_n, .o_wait_state);
`default_nettype wire
